// ### src/escaped_opcode_map.vh
// opcode values, cycle counts and reset values for the escaped opcode decoder
// assumes inclusion by the decoder module only; definitions only
`ifndef ESCAPED_OPCODE_MAP_VH
`define ESCAPED_OPCODE_MAP_VH

// ************************************************************
// escape prefix and escaped second bytes
// ************************************************************
`define OP_ESCAPE        8'hA5
`define ESC_BREAK        8'h00
`define ESC_MAC_ASR      8'h03
`define ESC_MAC_CLR      8'hE4
`define ESC_CMP_R0       8'hB6
`define ESC_CMP_R1       8'hB7
`define ESC_LOAD_ALT     8'h90
`define ESC_CODE_ALT     8'h93
`define ESC_RD_ALT       8'hE0
`define ESC_WR_ALT       8'hF0

// ************************************************************
// standard opcodes with special timing
// ************************************************************
`define OP_PUSH          8'hC0
`define OP_POP           8'hD0
`define OP_LONG_CALL     8'h12
`define OP_RET           8'h22
`define OP_RETI          8'h32
`define OP_RD_SEL        8'hE0
`define OP_WR_SEL        8'hF0
`define OP_CODE_SEL      8'h93
`define OP_LOAD_SEL      8'h90

// ************************************************************
// cycle counts
// ************************************************************
`define CYC_ONE          4'h1
`define CYC_STACK        4'h2
`define CYC_STACK_EXT    4'h3
`define CYC_CALL         4'h4
`define CYC_CALL_EXT     4'h6
`define CYC_RET          4'h4
`define CYC_RET_EXT      4'h5
`define CYC_SEL_RAM      4'h2
`define CYC_SEL_OTHER    4'h4
`define CYC_ALT_RAM      4'h3
`define CYC_ALT_OTHER    4'h5
`define CYC_CODE_SEL     4'h3
`define CYC_LOAD_SEL     4'h3
`define CYC_ESC_SHORT    4'h2
`define CYC_ESC_LONG     4'h4

// ************************************************************
// reset values
// ************************************************************
`define RST_PC           16'h0000
`define RST_PTR          16'h0000
`define RST_MAC          40'h00_0000_0000

`endif

// ### src/escaped_opcode_decode_timing.v
// escaped extension opcode decoder with per-instruction cycle timing
// assumes one opcode or operand byte offered per cycle on fetch_byte/fetch_valid,
// operand inputs (acc, indirect_data) steady in the finishing cycle, memory target steady when the opcode or escaped second byte is taken
`timescale 1ns/1ps
`include "escaped_opcode_map.vh"

// How it works
// - A5H prefix then second byte selects operation
// - selected pointer move external 2/4 cycles
// - alternate pointer move external 3/5 cycles
// - extended stack adds push/pop/call/return cycles
// - break enters debug handler when enabled
// - break otherwise two-cycle no-operation, flags kept
// - accumulator shift right keeps bit 39
// - accumulator clear zeros 40 bits, two cycles
// - compare branches when unequal, relative target
// - carry set when acc below indirect byte
// - compare via R0/R1 is A5 B6/B7, 4 cycles
// - alternate pointer immediate load A5 90, 4 cycles
// - code read acc plus alternate A5 93, 4 cycles
// - alternate pointer is the unselected one
module escaped_opcode_decode_timing (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        fetch_valid,
  input  wire [7:0]  fetch_byte,
  input  wire [7:0]  acc,
  input  wire [7:0]  indirect_data,
  input  wire        target_internal_extra_ram,
  input  wire        extended_stack_on,
  input  wire        debug_enable,
  input  wire        pointer_select_bit,
  output reg         fetch_ready,
  output reg  [15:0] pc,
  output reg         instr_done,
  output reg  [3:0]  instr_cycles,
  output reg  [39:0] mac_acc,
  output reg  [15:0] data_pointer0,
  output reg  [15:0] data_pointer1,
  output reg         carry,
  output reg         on_chip_debug_handler_entry,
  output reg  [15:0] access_addr,
  output reg         ext_read,
  output reg         ext_write,
  output reg         code_read
);

  // ************************************************************
  // states
  // ************************************************************
  localparam [1:0] S_FIRST = 2'd0;
  localparam [1:0] S_ESC   = 2'd1;
  localparam [1:0] S_OPER  = 2'd2;
  localparam [1:0] S_WAIT  = 2'd3;

  reg [1:0] state;
  reg [7:0] opcode;     // first byte, or second byte when escaped
  reg       escaped;
  reg [1:0] need;       // operand bytes still to fetch
  reg       have_first; // first operand byte stored
  reg [7:0] opnd;       // first operand byte
  reg [3:0] used;       // cycles spent so far
  reg [3:0] total;      // cycles the instruction takes

  // ************************************************************
  // decode helpers
  // ************************************************************
  // cycles of a standard opcode
  function [3:0] std_cycles;
    input [7:0] op;
    input       internal_extra_ram;
    input       xstk;
    begin
      case (op)
        `OP_PUSH, `OP_POP:    std_cycles = xstk ? `CYC_STACK_EXT : `CYC_STACK;
        `OP_LONG_CALL:        std_cycles = xstk ? `CYC_CALL_EXT : `CYC_CALL;
        `OP_RET, `OP_RETI:    std_cycles = xstk ? `CYC_RET_EXT : `CYC_RET;
        `OP_RD_SEL, `OP_WR_SEL: std_cycles = internal_extra_ram ? `CYC_SEL_RAM : `CYC_SEL_OTHER;
        `OP_CODE_SEL:         std_cycles = `CYC_CODE_SEL;
        `OP_LOAD_SEL:         std_cycles = `CYC_LOAD_SEL;
        default:              std_cycles = `CYC_ONE;
      endcase
    end
  endfunction

  // operand bytes after a standard opcode
  function [1:0] std_len;
    input [7:0] op;
    begin
      case (op)
        `OP_PUSH, `OP_POP:           std_len = 2'd1;
        `OP_LONG_CALL, `OP_LOAD_SEL: std_len = 2'd2;
        default:                     std_len = 2'd0;
      endcase
    end
  endfunction

  // cycles of an escaped second byte
  function [3:0] esc_cycles;
    input [7:0] op;
    input       internal_extra_ram;
    begin
      case (op)
        `ESC_RD_ALT, `ESC_WR_ALT: esc_cycles = internal_extra_ram ? `CYC_ALT_RAM : `CYC_ALT_OTHER;
        `ESC_CMP_R0, `ESC_CMP_R1: esc_cycles = `CYC_ESC_LONG;
        `ESC_LOAD_ALT, `ESC_CODE_ALT: esc_cycles = `CYC_ESC_LONG;
        default:                  esc_cycles = `CYC_ESC_SHORT;
      endcase
    end
  endfunction

  // operand bytes after an escaped second byte
  function [1:0] esc_len;
    input [7:0] op;
    begin
      case (op)
        `ESC_CMP_R0, `ESC_CMP_R1: esc_len = 2'd1;
        `ESC_LOAD_ALT:            esc_len = 2'd2;
        default:                  esc_len = 2'd0;
      endcase
    end
  endfunction

  // ************************************************************
  // byte take and finish detection
  // ************************************************************
  wire       take      = fetch_ready & fetch_valid;
  wire [3:0] used_now  = used + 4'd1;
  wire [7:0] last_byte = take ? fetch_byte : opnd;
  wire [15:0] sel_ptr  = pointer_select_bit ? data_pointer1 : data_pointer0;
  wire [15:0] other_ptr = pointer_select_bit ? data_pointer0 : data_pointer1;
  wire [15:0] code_sum  = other_ptr + {8'h00, acc};
  wire [15:0] code_sum_sel = sel_ptr + {8'h00, acc};
  wire [15:0] pc_branch = pc + {{8{opnd[7]}}, opnd};

  reg       finish;
  reg [3:0] fin_total;

  // finish when all bytes are in and the cycle budget is spent
  always @* begin
    finish    = 1'b0;
    fin_total = total;
    case (state)
      S_FIRST: begin
        fin_total = std_cycles(fetch_byte, target_internal_extra_ram, extended_stack_on);
        finish    = take && (fetch_byte != `OP_ESCAPE) && (std_len(fetch_byte) == 2'd0) &&
                    (fin_total <= 4'd1);
      end
      S_ESC: begin
        fin_total = esc_cycles(fetch_byte, target_internal_extra_ram);
        finish    = take && (esc_len(fetch_byte) == 2'd0) && (fin_total <= 4'd2);
      end
      S_OPER:  finish = take && (need == 2'd1) && (used_now >= total);
      S_WAIT:  finish = (used_now >= total);
      default: finish = 1'b0;
    endcase
  end

  // ************************************************************
  // sequencer and execution
  // ************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= S_FIRST;
      fetch_ready  <= 1'b1;
      opcode       <= 8'h00;
      escaped      <= 1'b0;
      need         <= 2'd0;
      have_first   <= 1'b0;
      opnd         <= 8'h00;
      used         <= 4'h0;
      total        <= 4'h0;
      pc           <= `RST_PC;
      instr_done   <= 1'b0;
      instr_cycles <= 4'h0;
      mac_acc      <= `RST_MAC;
      data_pointer0 <= `RST_PTR;
      data_pointer1 <= `RST_PTR;
      carry        <= 1'b0;
      on_chip_debug_handler_entry <= 1'b0;
      access_addr  <= 16'h0000;
      ext_read     <= 1'b0;
      ext_write    <= 1'b0;
      code_read    <= 1'b0;
    end else begin
      instr_done  <= finish;
      on_chip_debug_handler_entry <= 1'b0;
      ext_read    <= 1'b0;
      ext_write   <= 1'b0;
      code_read   <= 1'b0;
      if (take) begin
        pc <= pc + 16'h0001;
      end
      // byte intake and state moves
      case (state)
        S_FIRST: begin
          if (take) begin
            used       <= 4'h1;
            opcode     <= fetch_byte;
            have_first <= 1'b0;
            if (fetch_byte == `OP_ESCAPE) begin
              escaped <= 1'b1;
              state   <= S_ESC;
            end else begin
              escaped <= 1'b0;
              total   <= fin_total;
              need    <= std_len(fetch_byte);
              if (std_len(fetch_byte) != 2'd0) begin
                state <= S_OPER;
              end else if (!finish) begin
                state       <= S_WAIT;
                fetch_ready <= 1'b0;
              end
            end
          end
        end
        S_ESC: begin
          if (take) begin
            used   <= used_now;
            opcode <= fetch_byte;
            total  <= fin_total;
            need   <= esc_len(fetch_byte);
            if (esc_len(fetch_byte) != 2'd0) begin
              state <= S_OPER;
            end else if (finish) begin
              state <= S_FIRST;
            end else begin
              state       <= S_WAIT;
              fetch_ready <= 1'b0;
            end
          end
        end
        S_OPER: begin
          if (take) begin
            used <= used_now;
            need <= need - 2'd1;
            if (!have_first) begin
              opnd       <= fetch_byte;
              have_first <= 1'b1;
            end
            if (need == 2'd1) begin
              if (finish) begin
                state <= S_FIRST;
              end else begin
                state       <= S_WAIT;
                fetch_ready <= 1'b0;
              end
            end
          end
        end
        S_WAIT: begin
          used <= used_now;
          if (finish) begin
            state       <= S_FIRST;
            fetch_ready <= 1'b1;
          end
        end
        default: begin
          state       <= S_FIRST;
          fetch_ready <= 1'b1;
        end
      endcase
      // effects in the last cycle of an instruction
      if (finish) begin
        instr_cycles <= fin_total;
        if (state != S_FIRST && escaped) begin
          case ((state == S_ESC) ? fetch_byte : opcode)
            `ESC_BREAK: begin
              on_chip_debug_handler_entry <= debug_enable;
            end
            `ESC_MAC_ASR: mac_acc <= {mac_acc[39], mac_acc[39:1]};
            `ESC_MAC_CLR: mac_acc <= `RST_MAC;
            `ESC_CMP_R0, `ESC_CMP_R1: begin
              carry <= (acc < indirect_data);
              if (acc != indirect_data) begin
                pc <= pc_branch;
              end
            end
            `ESC_LOAD_ALT: begin
              if (pointer_select_bit) begin
                data_pointer0 <= {opnd, last_byte};
              end else begin
                data_pointer1 <= {opnd, last_byte};
              end
            end
            `ESC_CODE_ALT: begin
              access_addr <= code_sum;
              code_read   <= 1'b1;
            end
            `ESC_RD_ALT, `ESC_WR_ALT: begin
              // alternate read or write, always ends in wait
              access_addr <= other_ptr;
              ext_read    <= ~opcode[4];
              ext_write   <= opcode[4];
            end
            default: access_addr <= access_addr;
          endcase
        end else if (!escaped || state == S_FIRST) begin
          case ((state == S_FIRST) ? fetch_byte : opcode)
            `OP_RD_SEL, `OP_WR_SEL: begin
              // selected pointer access, always ends in wait
              access_addr <= sel_ptr;
              ext_read    <= ~opcode[4];
              ext_write   <= opcode[4];
            end
            `OP_CODE_SEL: begin
              access_addr <= code_sum_sel;
              code_read   <= 1'b1;
            end
            default: access_addr <= access_addr;
          endcase
        end
      end
    end
  end

endmodule // escaped_opcode_decode_timing

// ### tb/decode_checker_assertions.sv
// port assertions for the escaped opcode decoder
// assumes binding onto escaped_opcode_decode_timing, one clock domain
`timescale 1ns/1ps
module decode_checker (
  input logic        clk,
  input logic        rst_n,
  input logic        fetch_valid,
  input logic [7:0]  fetch_byte,
  input logic        fetch_ready,
  input logic [15:0] pc,
  input logic        instr_done,
  input logic [3:0]  instr_cycles,
  input logic [39:0] mac_acc,
  input logic [15:0] data_pointer0,
  input logic [15:0] data_pointer1,
  input logic        carry,
  input logic        on_chip_debug_handler_entry,
  input logic [7:0]  acc,
  input logic [7:0]  indirect_data,
  input logic        debug_enable,
  input logic        pointer_select_bit,
  input logic        target_internal_extra_ram,
  input logic        ext_read,
  input logic        ext_write,
  input logic        code_read
);
  logic [39:0] prev_mac;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // accumulator one cycle back, for the shift check
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) prev_mac <= 40'h00_0000_0000;
    else prev_mac <= mac_acc;
  end
  // ****
  // escape sequences
  // ****
  sequence take(logic [7:0] b);
    fetch_valid && fetch_ready && fetch_byte == b;
  endsequence
  sequence esc(logic [7:0] b);
    take(8'hA5) ##1 take(b);
  endsequence
  sequence cmp_seq;
    take(8'hA5) ##1 (fetch_valid && fetch_ready && fetch_byte[7:1] == 7'h5B) ##1 (fetch_valid && fetch_ready);
  endsequence
  sequence alt_load;
    esc(8'h90) ##1 (fetch_valid && fetch_ready) ##1 (fetch_valid && fetch_ready);
  endsequence
  chk_debug_cause: assert property (
    on_chip_debug_handler_entry |-> instr_done && $past(debug_enable)) else $error("debug entry out of place");
  chk_strobe_done: assert property (
    (ext_read || ext_write || code_read) |-> instr_done) else $error("access strobe without done");
  chk_mac_clear: assert property (
    esc(8'hE4) |=> instr_done && instr_cycles == 4'h2 && mac_acc == 40'h00_0000_0000) else $error("clear wrong");
  chk_mac_shift: assert property (
    esc(8'h03) |=> instr_done && mac_acc == {prev_mac[39], prev_mac[39:1]}) else $error("shift wrong");
  chk_break_step: assert property (
    esc(8'h00) |=> instr_done && instr_cycles == 4'h2 && pc == $past(pc, 2) + 16'h0002) else $error("break step");
  chk_cmp_timing: assert property (
    cmp_seq |=> !fetch_ready ##1 (instr_done && instr_cycles == 4'h4)) else $error("compare timing");
  chk_cmp_carry: assert property (
    cmp_seq |=> ##1 carry == ($past(acc) < $past(indirect_data))) else $error("compare carry");
  chk_carry_source: assert property (
    $changed(carry) |-> instr_done) else $error("carry changed outside an instruction end");
  chk_alt_load: assert property (
    alt_load |=> instr_done && instr_cycles == 4'h4
      && ($past(pointer_select_bit) ? data_pointer0 : data_pointer1) == {$past(fetch_byte, 2), $past(fetch_byte)})
    else $error("alternate load wrong");
  chk_alt_read: assert property (
    esc(8'hE0) |-> if (target_internal_extra_ram) ##2 (instr_done && ext_read) else ##4 (instr_done && ext_read))
    else $error("alternate read timing");
endmodule // decode_checker

bind escaped_opcode_decode_timing decode_checker chk_u (
  .clk (clk), .rst_n (rst_n), .fetch_valid (fetch_valid), .fetch_byte (fetch_byte),
  .fetch_ready (fetch_ready), .pc (pc), .instr_done (instr_done), .instr_cycles (instr_cycles),
  .mac_acc (mac_acc), .data_pointer0 (data_pointer0), .data_pointer1 (data_pointer1), .carry (carry),
  .on_chip_debug_handler_entry (on_chip_debug_handler_entry), .acc (acc), .indirect_data (indirect_data),
  .debug_enable (debug_enable), .pointer_select_bit (pointer_select_bit),
  .target_internal_extra_ram (target_internal_extra_ram), .ext_read (ext_read), .ext_write (ext_write),
  .code_read (code_read)
);

// ### tb/code_memory.sv
// program memory model offering code bytes at the program counter
// assumes the bench loads code and sets the fetch window before each run
`timescale 1ns/1ps
module code_memory (
  input  logic        clk,
  input  logic [15:0] pc,
  input  logic [15:0] start,
  input  logic [2:0]  count,
  input  logic        stall_en,
  output logic        fetch_valid = 1'b0,
  output logic [7:0]  fetch_byte = 8'h00
);
  logic [7:0] mem [0:65535];
  // ****
  // byte offer
  // ****
  // offer window bytes only, stalls at random; outside it the bus toggles
  always @(negedge clk) begin
    fetch_valid <= (pc - start < count) && !(stall_en && $urandom_range(3) == 0);
    fetch_byte  <= (pc - start < count) ? mem[pc] : ~fetch_byte;
  end
endmodule // code_memory

// ### tb/tb_top.sv
// self-checking bench for the escaped opcode decoder
// assumes the code memory model feeds bytes at the program counter
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  acc = 8'h00;
  logic [7:0]  indirect_data = 8'h00;
  logic        target_internal_extra_ram = 1'b0;
  logic        extended_stack_on = 1'b0;
  logic        debug_enable = 1'b0;
  logic        pointer_select_bit = 1'b0;
  logic [15:0] start = 16'h0000;
  logic [2:0]  count = 3'h0;
  logic        stall_en = 1'b0;
  wire         fetch_valid, fetch_ready, instr_done, carry;
  wire         on_chip_debug_handler_entry, ext_read, ext_write, code_read;
  wire  [7:0]  fetch_byte;
  wire  [3:0]  instr_cycles;
  wire  [15:0] pc, data_pointer0, data_pointer1, access_addr;
  wire  [39:0] mac_acc;
  int          failures = 0;
  int          comparisons = 0;
  int          cycle_count = 0;
  int          i;
  logic [7:0]  rel;
  logic [7:0]  op;
  logic        keep_carry;
  logic [15:0] model_ptr [2];
  logic [7:0]  one_ops [8] = '{8'h23, 8'h03, 8'h13, 8'h33, 8'hC4, 8'hE8, 8'hF8, 8'hC8};

  escaped_opcode_decode_timing dut_u (
    .clk (clk), .rst_n (rst_n), .fetch_valid (fetch_valid), .fetch_byte (fetch_byte), .acc (acc),
    .indirect_data (indirect_data), .target_internal_extra_ram (target_internal_extra_ram),
    .extended_stack_on (extended_stack_on), .debug_enable (debug_enable),
    .pointer_select_bit (pointer_select_bit), .fetch_ready (fetch_ready), .pc (pc),
    .instr_done (instr_done), .instr_cycles (instr_cycles), .mac_acc (mac_acc),
    .data_pointer0 (data_pointer0), .data_pointer1 (data_pointer1), .carry (carry),
    .on_chip_debug_handler_entry (on_chip_debug_handler_entry), .access_addr (access_addr),
    .ext_read (ext_read), .ext_write (ext_write), .code_read (code_read)
  );
  code_memory mem_u (
    .clk (clk), .pc (pc), .start (start), .count (count), .stall_en (stall_en),
    .fetch_valid (fetch_valid), .fetch_byte (fetch_byte)
  );

  // ****
  // clock, timeout, checking
  // ****
  initial forever #10 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == 5000) begin
      failures++;
      print_verdict;
    end
  end
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // load one instruction at pc, run it, check cycles, next pc, strobes
  task automatic exec(input logic [31:0] code, input int nb, input logic [3:0] cyc,
                      input logic [15:0] jump, input logic [3:0] strobes);
    int k;
    logic [15:0] base;
    @(negedge clk);
    base = pc;
    for (k = 0; k < nb; k++) mem_u.mem[base + k[15:0]] = code[31 - 8 * k -: 8];
    start = base;
    count = nb[2:0];
    stall_en = $urandom_range(1);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (instr_done !== 1'b1 && k < 60);
    check(instr_done, 1'b1);
    check(instr_cycles, cyc);
    check(pc, 16'(base + nb[15:0] + jump));
    check({on_chip_debug_handler_entry, code_read, ext_write, ext_read}, strobes);
    @(negedge clk);
  endtask

  // ****
  // scenarios
  // ****
  initial begin
    i = $urandom(32'h724d_03c5);
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    for (i = 0; i < 8; i++) exec({one_ops[i], 24'h0}, 1, 4'h1, 16'h0, 4'h0);
    for (i = 0; i < 2; i++) begin
      extended_stack_on = i[0];
      exec({8'hC0, 8'h30, 16'h0}, 2, i[0] ? 4'h3 : 4'h2, 16'h0, 4'h0);
      exec({8'hD0, 8'h30, 16'h0}, 2, i[0] ? 4'h3 : 4'h2, 16'h0, 4'h0);
      exec({8'h12, 8'h01, 8'h02, 8'h0}, 3, i[0] ? 4'h6 : 4'h4, 16'h0, 4'h0);
      exec({8'h22, 24'h0}, 1, i[0] ? 4'h5 : 4'h4, 16'h0, 4'h0);
      exec({8'h32, 24'h0}, 1, i[0] ? 4'h5 : 4'h4, 16'h0, 4'h0);
    end
    // model: the escaped load writes the unselected pointer
    pointer_select_bit = 1'b0;
    model_ptr[!pointer_select_bit] = 16'h1234;
    exec(32'hA590_1234, 4, 4'h4, 16'h0, 4'h0);
    check(data_pointer1, model_ptr[1]);
    pointer_select_bit = 1'b1;
    model_ptr[!pointer_select_bit] = 16'h5678;
    exec(32'hA590_5678, 4, 4'h4, 16'h0, 4'h0);
    check(data_pointer0, model_ptr[0]);
    exec(32'h90AB_CD00, 3, 4'h3, 16'h0, 4'h0);
    check({data_pointer1, data_pointer0}, {model_ptr[1], model_ptr[0]});
    for (i = 0; i < 8; i++) begin
      pointer_select_bit = i[0];
      target_internal_extra_ram = i[1];
      op = i[2] ? 8'hF0 : 8'hE0;
      exec({op, 24'h0}, 1, i[1] ? 4'h2 : 4'h4, 16'h0, {2'b00, i[2], !i[2]});
      check(access_addr, model_ptr[i[0]]);
      exec({8'hA5, op, 16'h0}, 2, i[1] ? 4'h3 : 4'h5, 16'h0, {2'b00, i[2], !i[2]});
      check(access_addr, model_ptr[!i[0]]);
      acc = $urandom;
      exec(32'hA593_0000, 2, 4'h4, 16'h0, 4'h4);
      check(access_addr, 16'(model_ptr[!i[0]] + {8'h00, acc}));
      exec(32'h9300_0000, 1, 4'h3, 16'h0, 4'h4);
      check(access_addr, 16'(model_ptr[i[0]] + {8'h00, acc}));
    end
    exec(32'hA5E4_0000, 2, 4'h2, 16'h0, 4'h0);
    check(mac_acc, 40'h00_0000_0000);
    exec(32'hA503_0000, 2, 4'h2, 16'h0, 4'h0);
    check(mac_acc, 40'h00_0000_0000);
    for (i = 0; i < 5; i++) exec({8'hA5, 8'h55 + 8'h1E * i[7:0], 16'h0}, 2, 4'h2, 16'h0, 4'h0);
    for (i = 0; i < 12; i++) begin
      acc = $urandom;
      indirect_data = $urandom_range(1) ? acc : $urandom;
      rel = $urandom;
      if (rel == 8'hA5 || rel > 8'hFC) rel = 8'h5A;
      op = 8'hB6 + {7'h00, i[0]};
      exec({8'hA5, op, rel, 8'h0}, 3, 4'h4, acc != indirect_data ? {{8{rel[7]}}, rel} : 16'h0, 4'h0);
      check(carry, acc < indirect_data);
      keep_carry = carry;
      debug_enable = i[1];
      exec(32'hA500_0000, 2, 4'h2, 16'h0, {i[1], 3'b000});
      check(carry, keep_carry);
    end
    print_verdict;
  end
endmodule // tb_top
